/* hdl/mssi_pkg.sv */
// package: constants and carrier types of the slot status and interrupt block
package mssi_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned REF_CLK_MHZ  = 25;
    localparam int unsigned TIMEOUT_NS   = 8000;
    // longest wait, so the cycle count rounds down
    localparam int unsigned TIMEOUT_CYC  = TIMEOUT_NS * REF_CLK_MHZ / 1000;
    localparam int unsigned TIMEOUT_CW   = 8;
    localparam int unsigned LED_MS       = 200;
    localparam int unsigned LED_CYC      = LED_MS * REF_CLK_MHZ * 1000;
    localparam int unsigned LED_W        = 23;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  REG_CTL_A    = 8'h02;
    localparam logic [7:0]  REG_CTL_B    = 8'h04;
    localparam logic [7:0]  REG_STAT     = 8'h0C;
    // control fields sit in bits 7..2 of each slot control register
    localparam int unsigned CTL_LSB      = 2;
    localparam int unsigned CTL_MSB      = 7;
    localparam logic [5:0]  CTL_RESET    = 6'h00;
    // status field positions
    localparam int unsigned STAT_TIME_LSB = 12;
    localparam int unsigned STAT_ERR_LSB  = 8;
    localparam int unsigned STAT_REQ_LSB  = 0;
    localparam logic [15:0] ALL_ONES      = 16'hFFFF;
    localparam logic [15:0] READ_ZERO     = 16'h0000;

    // ****************************************************************
    // types
    // ****************************************************************
    // slot control fields, bit 7 down to bit 2
    typedef struct packed {
        logic request1_enable;
        logic request0_enable;
        logic request1_edge_select;
        logic request0_edge_select;
        logic err_irq_enable;
        logic timeout_irq_enable;
    } mssi_ctl_s;

    // one slot access from the host bridge; addr[0] is module address A1
    typedef struct packed {
        logic        write;
        logic        intack;
        logic        slot;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } mssi_cmd_s;

    typedef enum logic [2:0] {
        R_IDLE  = 3'h1,
        R_WAIT  = 3'h2,
        R_DRAIN = 3'h4
    } mssi_rstate_e;

    typedef enum logic [2:0] {
        L_IDLE  = 3'h1,
        L_SEL   = 3'h2,
        L_ABRT  = 3'h4
    } mssi_lstate_e;

endpackage

/* hdl/mssi_top.sv */
// module: slot status, interrupt merge and module access engine of a two-slot carrier
//
// Contract
// - flag slot timeout after about 8 us
// - timeout never reported to host as error
// - timed-out read returns all ones
// - enabled timeout interrupt holds until write-one
// - bits 13/12 sticky timeout, write-one clears
// - bits 9/8 live error lines, read only
// - bits 3..0 report the four request lines
// - write-one clears latched edge request status
// - all sources merge onto one interrupt line
// - int space read runs acknowledge, A1 picks line
// - acknowledge cycle data returned as vector
// - error interrupt removed by enable bit or error line release
// - access indicator lit 200 ms, retriggers
// - control bits 5/4 pick edge or level
// - control bits 7,6,3,2 enable sources
`timescale 1ns/1ps
module mssi_top
    import mssi_pkg::*;
#(
    parameter logic [LED_W-1:0] LED_CYCLES = LED_W'(LED_CYC)
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        link_clk,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        acc_req,
    input  wire mssi_cmd_s   acc_cmd,
    output logic             acc_busy,
    output logic             acc_done,
    output logic      [15:0] acc_rdata,
    output logic      [1:0]  io_sel_n,
    output logic      [1:0]  int_sel_n,
    output logic      [5:0]  ip_addr,
    output logic             ip_rw_n,
    output logic      [15:0] ip_data_o,
    output logic             ip_data_oe,
    input  wire logic [15:0] ip_data_i,
    input  wire logic [1:0]  ip_ack_n,
    input  wire logic [1:0]  module_err_n,
    input  wire logic [1:0]  module_request0_n,
    input  wire logic [1:0]  module_request1_n,
    output logic      [1:0]  access_led,
    output logic             inta_n
);

    // ****************************************************************
    // state of both domains
    // ****************************************************************
    typedef struct packed {
        mssi_rstate_e           st;
        mssi_cmd_s              cmd;
        logic [TIMEOUT_CW-1:0]  tcnt;
        logic                   req_tgl;
        logic                   abort;
        logic [2:0]             dsync;
        logic                   dflt;
        logic [5:0]             p1;
        logic [5:0]             p2;
        logic [5:0]             p3;
        logic [5:0]             pf;
        logic [3:0]             elatch;
        logic [1:0]             tflag;
        mssi_ctl_s [1:0]        ctl;
        logic [1:0][LED_W-1:0]  lcnt;
        logic [1:0]             led;
        logic [15:0]            rdata;
        logic [15:0]            adata;
        logic                   adone;
        logic                   inta_n;
    } mssi_ref_s;

    typedef struct packed {
        mssi_lstate_e st;
        logic [2:0]   tsync;
        logic         tflt;
        logic         tprev;
        logic [2:0]   async;
        logic         aflt;
        logic         done_tgl;
        logic [15:0]  data;
        logic [1:0]   sel_n;
        logic [1:0]   isel_n;
        logic [5:0]   addr;
        logic         rw_n;
        logic [15:0]  dout;
        logic         doe;
    } mssi_link_s;

    mssi_ref_s  ref_reg;
    mssi_ref_s  ref_next;
    mssi_link_s link_reg;
    mssi_link_s link_next;

    // a change counts once the second and third stage agree
    function automatic logic agree(input logic s2, input logic s3, input logic prev);
        return (s2 == s3) ? s3 : prev;
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
        return addr == offs;
    endfunction

    // request line index i: slot i/2, line i%2
    function automatic logic req_on(input mssi_ctl_s c, input logic line);
        return line ? c.request1_enable : c.request0_enable;
    endfunction

    function automatic logic req_edge(input mssi_ctl_s c, input logic line);
        return line ? c.request1_edge_select : c.request0_edge_select;
    endfunction

    // ****************************************************************
    // host-side logic on ref_clk
    // ****************************************************************
    logic [3:0] req_stat;
    logic [3:0] rise;
    logic [1:0] tset;
    logic [1:0] tclr;
    logic [3:0] eclr;
    logic       dedge;
    logic       stat_wr;
    logic       irq;

    // status view of the request lines, from registered state
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            req_stat[i] = req_edge(ref_reg.ctl[i/2], 1'(i % 2))
                        ? ref_reg.elatch[i] : ref_reg.pf[2+i];
        end
    end

    always_comb begin
        ref_next       = ref_reg;
        ref_next.adone = 1'b0;
        tset           = 2'b00;
        // pins are active low; invert before the three-stage filter
        ref_next.p1    = {~module_request1_n[1], ~module_request0_n[1],
                          ~module_request1_n[0], ~module_request0_n[0], ~module_err_n};
        ref_next.p2    = ref_reg.p1;
        ref_next.p3    = ref_reg.p2;
        for (int i = 0; i < 6; i++) begin
            ref_next.pf[i] = agree(ref_reg.p2[i], ref_reg.p3[i], ref_reg.pf[i]);
        end
        rise           = ref_next.pf[5:2] & ~ref_reg.pf[5:2];
        // done toggle from the link side, same filter
        ref_next.dsync = {ref_reg.dsync[1:0], link_reg.done_tgl};
        ref_next.dflt  = agree(ref_reg.dsync[1], ref_reg.dsync[2], ref_reg.dflt);
        dedge          = ref_next.dflt ^ ref_reg.dflt;

        // access indicator counters count down
        for (int s = 0; s < 2; s++) begin
            if (ref_reg.lcnt[s] != '0) begin
                ref_next.lcnt[s] = ref_reg.lcnt[s] - LED_W'(1);
            end
        end

        // slot access sequencing and timeout watch
        case (ref_reg.st)
            R_IDLE: begin
                if (acc_req) begin
                    ref_next.cmd                   = acc_cmd;
                    ref_next.req_tgl               = ~ref_reg.req_tgl;
                    ref_next.tcnt                  = '0;
                    ref_next.lcnt[acc_cmd.slot]    = LED_CYCLES;
                    ref_next.st                    = R_WAIT;
                end
            end
            R_WAIT: begin
                if (dedge) begin
                    // link data is held stable from its done toggle on
                    ref_next.adata = link_reg.data;
                    ref_next.adone = 1'b1;
                    ref_next.st    = R_IDLE;
                end else if (ref_reg.tcnt == TIMEOUT_CW'(TIMEOUT_CYC - 1)) begin
                    tset[ref_reg.cmd.slot] = 1'b1;
                    ref_next.adata = ALL_ONES;
                    ref_next.adone = 1'b1;
                    ref_next.abort = 1'b1;
                    ref_next.st    = R_DRAIN;
                end else begin
                    ref_next.tcnt  = ref_reg.tcnt + TIMEOUT_CW'(1);
                end
            end
            R_DRAIN: begin
                // wait until the link side has let go of the module
                if (dedge) begin
                    ref_next.abort = 1'b0;
                    ref_next.st    = R_IDLE;
                end
            end
            default: begin
                ref_next.st = R_IDLE;
            end
        endcase

        for (int s = 0; s < 2; s++) begin
            ref_next.led[s] = ref_next.lcnt[s] != '0;
        end

        // register writes; error bits are never written
        stat_wr = reg_wr && hit(reg_addr, REG_STAT);
        tclr    = stat_wr ? reg_wdata[STAT_TIME_LSB +: 2] : 2'b00;
        eclr    = stat_wr ? reg_wdata[STAT_REQ_LSB +: 4] : 4'h0;
        if (reg_wr && hit(reg_addr, REG_CTL_A)) begin
            ref_next.ctl[0] = reg_wdata[CTL_MSB:CTL_LSB];
        end
        if (reg_wr && hit(reg_addr, REG_CTL_B)) begin
            ref_next.ctl[1] = reg_wdata[CTL_MSB:CTL_LSB];
        end

        // sticky flags: a set in the clearing cycle wins
        ref_next.tflag = (ref_reg.tflag & ~tclr) | tset;
        for (int i = 0; i < 4; i++) begin
            ref_next.elatch[i] = req_edge(ref_reg.ctl[i/2], 1'(i % 2))
                               ? ((ref_reg.elatch[i] & ~eclr[i]) | rise[i]) : 1'b0;
        end

        // read data, one cycle after the strobe
        if (reg_rd) begin
            if (hit(reg_addr, REG_STAT)) begin
                ref_next.rdata = {2'b00, ref_reg.tflag, 2'b00, ref_reg.pf[1:0],
                                  4'h0, req_stat};
            end else if (hit(reg_addr, REG_CTL_A)) begin
                ref_next.rdata = {8'h00, ref_reg.ctl[0], 2'b00};
            end else if (hit(reg_addr, REG_CTL_B)) begin
                ref_next.rdata = {8'h00, ref_reg.ctl[1], 2'b00};
            end else begin
                ref_next.rdata = READ_ZERO;
            end
        end

        // level requests follow the module; nothing here clears them
        irq = 1'b0;
        for (int i = 0; i < 4; i++) begin
            irq = irq | (req_on(ref_reg.ctl[i/2], 1'(i % 2)) & req_stat[i]);
        end
        for (int s = 0; s < 2; s++) begin
            irq = irq | (ref_reg.ctl[s].err_irq_enable & ref_reg.pf[s])
                      | (ref_reg.ctl[s].timeout_irq_enable & ref_reg.tflag[s]);
        end
        ref_next.inta_n = ~irq;
    end

    // host-side register stage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_reg        <= '0;
            ref_reg.st     <= R_IDLE;
            ref_reg.inta_n <= 1'b1;
        end else begin
            ref_reg <= ref_next;
        end
    end

    // ****************************************************************
    // module-side logic on link_clk
    // ****************************************************************
    // command fields are read from ref_reg; they hold still while busy
    always_comb begin
        link_next       = link_reg;
        link_next.tsync = {link_reg.tsync[1:0], ref_reg.req_tgl};
        link_next.tflt  = agree(link_reg.tsync[1], link_reg.tsync[2], link_reg.tflt);
        link_next.async = {link_reg.async[1:0], ref_reg.abort};
        link_next.aflt  = agree(link_reg.async[1], link_reg.async[2], link_reg.aflt);
        case (link_reg.st)
            L_IDLE: begin
                // a stale abort must drain before a new cycle starts
                if ((link_reg.tflt != link_reg.tprev) && !link_reg.aflt) begin
                    link_next.tprev = link_reg.tflt;
                    link_next.rw_n  = ref_reg.cmd.intack | ~ref_reg.cmd.write;
                    link_next.doe   = ~(ref_reg.cmd.intack | ~ref_reg.cmd.write);
                    link_next.dout  = ref_reg.cmd.wdata;
                    if (ref_reg.cmd.intack) begin
                        // only A1 matters: line 0 or line 1
                        link_next.addr = {5'h00, ref_reg.cmd.addr[0]};
                        link_next.isel_n[ref_reg.cmd.slot] = 1'b0;
                    end else begin
                        link_next.addr = ref_reg.cmd.addr;
                        link_next.sel_n[ref_reg.cmd.slot] = 1'b0;
                    end
                    link_next.st = L_SEL;
                end
            end
            L_SEL: begin
                if (!ip_ack_n[ref_reg.cmd.slot]) begin
                    link_next.data     = ip_data_i;
                    link_next.sel_n    = 2'b11;
                    link_next.isel_n   = 2'b11;
                    link_next.doe      = 1'b0;
                    link_next.done_tgl = ~link_reg.done_tgl;
                    link_next.st       = L_IDLE;
                end else if (link_reg.aflt) begin
                    link_next.sel_n    = 2'b11;
                    link_next.isel_n   = 2'b11;
                    link_next.doe      = 1'b0;
                    link_next.done_tgl = ~link_reg.done_tgl;
                    link_next.st       = L_ABRT;
                end
            end
            L_ABRT: begin
                if (!link_reg.aflt) begin
                    link_next.st = L_IDLE;
                end
            end
            default: begin
                link_next.st = L_IDLE;
            end
        endcase
    end

    // module-side register stage
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_reg        <= '0;
            link_reg.st     <= L_IDLE;
            link_reg.sel_n  <= 2'b11;
            link_reg.isel_n <= 2'b11;
            link_reg.rw_n   <= 1'b1;
        end else begin
            link_reg <= link_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata  = ref_reg.rdata;
    assign acc_busy   = ref_reg.st != R_IDLE;
    assign acc_done   = ref_reg.adone;
    assign acc_rdata  = ref_reg.adata;
    assign access_led = ref_reg.led;
    assign inta_n     = ref_reg.inta_n;
    assign io_sel_n   = link_reg.sel_n;
    assign int_sel_n  = link_reg.isel_n;
    assign ip_addr    = link_reg.addr;
    assign ip_rw_n    = link_reg.rw_n;
    assign ip_data_o  = link_reg.dout;
    assign ip_data_oe = link_reg.doe;

endmodule // mssi_top

/* test/mssi_monitor.sv */
// port-level checker of the slot status and interrupt block
`timescale 1ns/1ps
module mssi_monitor
    import mssi_pkg::*;
#(
    parameter logic [LED_W-1:0] LED_CYCLES = LED_W'(LED_CYC)
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        acc_req,
    input wire mssi_cmd_s   acc_cmd,
    input wire logic        acc_busy,
    input wire logic        acc_done,
    input wire logic [15:0] acc_rdata,
    input wire logic [1:0]  io_sel_n,
    input wire logic [1:0]  int_sel_n,
    input wire logic        ip_rw_n,
    input wire logic        ip_data_oe,
    input wire logic [1:0]  access_led
);
    // ****************************************************************
    // helper logic
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [8:0] wait_reg;
    logic [8:0] wait_next;
    // cycles since the take, saturating so a long drain cannot wrap
    always_comb begin
        wait_next = wait_reg;
        if (acc_req && !acc_busy) begin
            wait_next = 9'h000;
        end else if (wait_reg != 9'h1FF) begin
            wait_next = wait_reg + 9'h001;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 9'h000;
        end else begin
            wait_reg <= wait_next;
        end
    end
    sequence take_s;
        acc_req && !acc_busy;
    endsequence
    sequence stat_rd_s;
        reg_rd && reg_addr == REG_STAT;
    endsequence
    // ****************************************************************
    // assertions
    // ****************************************************************
    stat_unused_a: assert property (stat_rd_s |=> (reg_rdata & 16'hCCF0) == 16'h0000)
        else $error("unused status bits not zero");
    ctl_fields_a: assert property ((reg_rd && (reg_addr == REG_CTL_A || reg_addr == REG_CTL_B))
        |=> reg_rdata[15:8] == 8'h00 && reg_rdata[1:0] == 2'h0)
        else $error("control unused bits not zero");
    timeout_bound_a: assert property (take_s |-> ##[1:201] acc_done)
        else $error("access not ended within timeout");
    timeout_data_a: assert property (acc_done && wait_reg >= 9'h0BE |-> acc_rdata == 16'hFFFF)
        else $error("timed-out read not all ones");
    led_on_a: assert property (take_s |-> ##2 access_led[$past(acc_cmd.slot, 2)])
        else $error("access indicator not lit");
    led_hold_a: assert property ($rose(access_led[0]) |-> access_led[0][*8])
        else $error("access indicator too short");
    intack_sel_a: assert property (take_s ##0 acc_cmd.intack
        |-> ##[1:40] (int_sel_n != 2'b11 && io_sel_n == 2'b11))
        else $error("acknowledge select missing");
    intack_read_a: assert property (int_sel_n != 2'b11 |-> ip_rw_n && !ip_data_oe)
        else $error("acknowledge cycle not a read");
endmodule // mssi_monitor

bind mssi_top mssi_monitor #(.LED_CYCLES(LED_CYCLES)) mon_u (.ref_clk, .rst_n, .reg_addr,
    .reg_rd, .reg_rdata, .acc_req, .acc_cmd, .acc_busy, .acc_done, .acc_rdata, .io_sel_n,
    .int_sel_n, .ip_rw_n, .ip_data_oe, .access_led);

/* test/mssi_slot_model.sv */
// model of two plug-in modules answering selects with an acknowledge
`timescale 1ns/1ps
module mssi_slot_model (
    input  wire logic        link_clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  io_sel_n,
    input  wire logic [1:0]  int_sel_n,
    input  wire logic [5:0]  ip_addr,
    input  wire logic [15:0] ip_data_o,
    input  wire logic        ip_data_oe,
    input  wire logic [1:0]  mute,
    input  wire logic [3:0]  ack_delay,
    output logic      [15:0] ip_data_i,
    output logic      [1:0]  ip_ack_n
);
    logic [15:0] data_reg = 16'h0000;
    logic [1:0]  ack_reg  = 2'b11;
    logic [3:0]  cnt_reg  = 4'h0;
    logic [1:0]  sel;
    logic        sl;
    assign sel       = ~io_sel_n | ~int_sel_n;
    assign sl        = sel[1];
    assign ip_data_i = data_reg;
    assign ip_ack_n  = ack_reg;
    // data only valid while acking; otherwise it flips so stale data never matches
    always @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 2'b11;
            cnt_reg <= 4'h0;
        end else if (sel == 2'b00) begin
            ack_reg  <= 2'b11;
            cnt_reg  <= 4'h0;
            data_reg <= ~data_reg;
        end else if (cnt_reg == ack_delay && !mute[sl]) begin
            ack_reg[sl] <= 1'b0;
            if (int_sel_n != 2'b11) begin
                data_reg <= {8'h5A, 7'h00, ip_addr[0]};
            end else begin
                data_reg <= ip_data_oe ? ip_data_o : {8'hC3, 1'b0, sl, ip_addr}; // writes echo
            end
        end else begin
            cnt_reg  <= cnt_reg + 4'h1;
            data_reg <= ~data_reg;
        end
    end
endmodule // mssi_slot_model

/* test/mssi_top_tb.sv */
// self-checking bench of the slot status and interrupt block
`timescale 1ns/1ps
module mssi_top_tb;
    import mssi_pkg::*;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    localparam logic [LED_W-1:0] LED_SIM = LED_W'(50);
    logic        ref_clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        acc_req = 1'b0;
    mssi_cmd_s   acc_cmd = '0;
    logic [1:0]  module_err_n = 2'b11;
    logic [1:0]  module_request0_n = 2'b11;
    logic [1:0]  module_request1_n = 2'b11;
    logic [1:0]  mute = 2'b00;
    logic [3:0]  dly = 4'h0;
    logic        acc_busy, acc_done, ip_rw_n, ip_data_oe, inta_n;
    logic [1:0]  io_sel_n, int_sel_n, ip_ack_n, access_led;
    logic [5:0]  ip_addr;
    logic [15:0] reg_rdata, acc_rdata, ip_data_o, ip_data_i, rd;
    int          err_total = 0;
    int          checked = 0;
    initial forever #20 ref_clk = ~ref_clk;
    // link clock offset so its edges never line up with the host clock
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    mssi_top #(.LED_CYCLES(LED_SIM)) dut_u (.ref_clk, .rst_n, .link_clk, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .acc_req, .acc_cmd, .acc_busy, .acc_done, .acc_rdata,
        .io_sel_n, .int_sel_n, .ip_addr, .ip_rw_n, .ip_data_o, .ip_data_oe, .ip_data_i,
        .ip_ack_n, .module_err_n, .module_request0_n, .module_request1_n, .access_led, .inta_n);
    mssi_slot_model model_u (.link_clk, .rst_n, .io_sel_n, .int_sel_n, .ip_addr, .mute,
        .ip_data_o, .ip_data_oe, .ack_delay(dly), .ip_data_i, .ip_ack_n);
    // ****************************************************************
    // bus tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        #1 chk(reg_rdata, exp);
    endtask
    // bounded waits: done first, then any drain after an aborted cycle
    task automatic acc(input logic w, ia, sl, input logic [5:0] a, output logic [15:0] d);
        int n;
        @(posedge ref_clk);
        acc_req <= 1'b1;
        acc_cmd <= '{write: w, intack: ia, slot: sl, addr: a, wdata: 16'h3C5A};
        @(posedge ref_clk);
        acc_req <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (acc_done !== 1'b1 && n < 400);
        d = acc_rdata;
        chk({15'h0000, acc_done}, 16'h0001);
        while (acc_busy !== 1'b0 && n < 800) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk({15'h0000, acc_busy}, 16'h0000);
    endtask
    task automatic inta_is(input logic v);
        repeat (3) @(posedge ref_clk);
        #1 chk({15'h0000, inta_n}, {15'h0000, v});
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        rdc(REG_STAT, 16'h0000);
        rdc(REG_CTL_B, 16'h0000);
        wr(REG_CTL_A, 16'hFFFF);
        rdc(REG_CTL_A, 16'h00FC);
        wr(REG_CTL_A, 16'h0000);
        wr(REG_STAT, 16'hFFFF);
        rdc(REG_STAT, 16'h0000);
        inta_is(1'b1);
    endtask
    task automatic t_io();
        acc(1'b0, 1'b0, 1'b0, 6'h05, rd);
        chk(rd, 16'hC305);
        repeat (30) @(posedge ref_clk);
        dly <= 4'h9;
        acc(1'b0, 1'b0, 1'b0, 6'h3F, rd);
        chk(rd, 16'hC33F);
        repeat (2) @(posedge ref_clk);
        #1 chk({14'h0000, access_led}, 16'h0001);
        dly <= 4'h0;
        acc(1'b1, 1'b0, 1'b1, 6'h2A, rd);
        chk(rd, 16'h3C5A);
        chk({15'h0000, access_led[1]}, 16'h0001);
        rdc(REG_STAT, 16'h0000);
        repeat (60) @(posedge ref_clk);
        #1 chk({14'h0000, access_led}, 16'h0000);
    endtask
    task automatic t_timeout();
        for (int s = 0; s < 2; s++) begin
            wr(s ? REG_CTL_B : REG_CTL_A, 16'h0004);
            mute <= 2'b01 << s;
            acc(1'b0, 1'b0, s[0], 6'h01, rd);
            chk(rd, 16'hFFFF);
            mute <= 2'b00;
            rdc(REG_STAT, 16'h1000 << s);
            inta_is(1'b0);
            wr(REG_STAT, 16'h0000);
            rdc(REG_STAT, 16'h1000 << s);
            wr(REG_STAT, 16'h1000 << s);
            rdc(REG_STAT, 16'h0000);
            inta_is(1'b1);
            wr(s ? REG_CTL_B : REG_CTL_A, 16'h0000);
        end
    endtask
    task automatic t_error();
        @(posedge ref_clk);
        module_err_n <= 2'b00;
        repeat (3) @(posedge ref_clk);
        rdc(REG_STAT, 16'h0300);
        inta_is(1'b1);
        wr(REG_CTL_A, 16'h0008);
        wr(REG_STAT, 16'hFFFF);
        rdc(REG_STAT, 16'h0300);
        inta_is(1'b0);
        wr(REG_CTL_A, 16'h0000);
        inta_is(1'b1);
        module_err_n <= 2'b11;
    endtask
    task automatic t_edge();
        wr(REG_CTL_A, 16'h0050);
        module_request0_n <= 2'b10;
        repeat (8) @(posedge ref_clk);
        module_request0_n <= 2'b11;
        rdc(REG_STAT, 16'h0001);
        inta_is(1'b0);
        wr(REG_STAT, 16'hFFFE);
        rdc(REG_STAT, 16'h0001);
        wr(REG_STAT, 16'h0001);
        rdc(REG_STAT, 16'h0000);
        inta_is(1'b1);
        wr(REG_CTL_A, 16'h0000);
    endtask
    task automatic t_level();
        @(posedge ref_clk);
        module_request0_n <= 2'b00;
        module_request1_n <= 2'b00;
        repeat (3) @(posedge ref_clk);
        rdc(REG_STAT, 16'h000F);
        inta_is(1'b1);
        wr(REG_CTL_B, 16'h0080);
        inta_is(1'b0);
        acc(1'b0, 1'b1, 1'b1, 6'h01, rd);
        chk(rd, 16'h5A01);
        module_request1_n <= 2'b10;
        acc(1'b0, 1'b1, 1'b0, 6'h00, rd);
        chk(rd, 16'h5A00);
        module_request0_n <= 2'b11;
        module_request1_n <= 2'b11;
        repeat (3) @(posedge ref_clk);
        rdc(REG_STAT, 16'h0000);
        inta_is(1'b1);
    endtask
    // ****************************************************************
    // run control
    // ****************************************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // reset spans two link edges so both domains see it
    initial begin
        repeat (2) @(posedge link_clk);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_io();
        t_timeout();
        t_error();
        t_edge();
        t_level();
        test_done();
    end
    // more than twenty times the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        test_done();
    end
endmodule // mssi_top_tb
